/* bench/ps_link_props.sv */
// concurrent checks on the configuration link between host and device
`timescale 1ns/1ps
`default_nettype none
module ps_link_props #(
  parameter int PorCycles = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link lines
  input wire logic configRequestN,
  input wire logic serialLoadClock,
  input wire logic statusLine,
  input wire logic doneLine,
  input wire logic chipSelectInN,
  input wire logic chainSelectOutN,
  input wire logic devStatusOeN,
  input wire logic devDoneOeN,
  input wire logic devDataOeN
);
  import ps_config_pkg::*;
  localparam int REQ_LAT = 8;
  typedef logic [16:0] cnt_t;
  cnt_t stLow, stReq, reqHi, reqLow, stHi, upCnt;
  cnt_t next_stLow, next_stReq, next_reqHi, next_reqLow, next_stHi, next_upCnt;
  function automatic cnt_t inc(input cnt_t v);
    return (v == 17'h1FFFF) ? v : v + 17'h1;
  endfunction
  // saturating run lengths of the link levels, and cycles since reset
  always_comb begin
    next_stLow = (reset || devStatusOeN) ? '0 : inc(stLow);
    next_stReq = (reset || devStatusOeN || !configRequestN) ? '0 : inc(stReq);
    next_reqHi = (reset || !configRequestN) ? '0 : inc(reqHi);
    next_reqLow = (reset || configRequestN) ? '0 : inc(reqLow);
    next_stHi = (reset || !statusLine) ? '0 : inc(stHi);
    next_upCnt = reset ? '0 : inc(upCnt);
  end
  always_ff @(posedge clk) begin
    stLow <= next_stLow;
    stReq <= next_stReq;
    reqHi <= next_reqHi;
    reqLow <= next_reqLow;
    stHi <= next_stHi;
    upCnt <= next_upCnt;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_req_fall_quiet: assert property (
    $fell(configRequestN) |-> ##[0:REQ_LAT] (!statusLine && !doneLine))
    else $error("status or done not low after request fall");
  a_por_status_low: assert property (
    upCnt < PorCycles |-> !devStatusOeN)
    else $error("status released during power-on delay");
  a_status_min_width: assert property (
    $rose(devStatusOeN) |-> stLow >= STATUS_MIN_CYC)
    else $error("status low pulse too short");
  a_status_max_low: assert property (
    !devStatusOeN |-> stReq <= STATUS_MAX_CYC)
    else $error("status held low too long");
  a_done_then_chain: assert property (
    $rose(devDoneOeN) |-> (!chainSelectOutN && statusLine))
    else $error("done released without chain select");
  a_unsel_no_done: assert property (
    chipSelectInN |-> !$rose(devDoneOeN))
    else $error("unselected device finished loading");
  a_no_early_drive: assert property (
    (!doneLine) [*3] |-> devDataOeN)
    else $error("data pin driven before load done");
  a_first_clock_wait: assert property (
    $rose(serialLoadClock) |-> reqHi >= CF2CK_CYC)
    else $error("link clock too soon after request");
  a_status_to_clock: assert property (
    $rose(serialLoadClock) |-> stHi >= ST2CK_CYC)
    else $error("link clock too soon after status");
  a_req_low_width: assert property (
    $rose(configRequestN) |-> reqLow >= CFG_LOW_CYC)
    else $error("request low pulse too short");
  a_clock_high_time: assert property (
    $rose(serialLoadClock) |-> serialLoadClock [*4])
    else $error("link clock high phase too short");
  c_done_rise: cover property ($rose(doneLine));
  c_chain_pass: cover property ($fell(chainSelectOutN));
  c_error_pulse: cover property ($fell(devStatusOeN) && configRequestN);
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench: host and device joined by the configuration link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ps_config_pkg::*;
  localparam int POR = 50;
  localparam int NB = 4;
  localparam int UCP = 4;
  localparam logic [31:0] GOOD = 32'h70563412;
  localparam logic [31:0] BAD = 32'h71563412;
  logic clk, reset, start, autoRestart, dataRelease, byteValid, byteReady;
  logic busy, configured, failed, useUserClock, dualPurposeDrive, ucDiv;
  logic userStartupClock, userDataOut, userMode, configError, userDataIn;
  logic [7:0] byteData;
  logic bitQ[$];
  int bad_count = 0;
  int total_checks = 0;
  int lowRun = 0;
  int lastLow = 0;
  int reqFalls = 0;
  config_link link();
  ps_config_host ps_config_host_i (.clk(clk), .reset(reset), .link(link.host),
    .start(start), .autoRestart(autoRestart), .dataRelease(dataRelease),
    .byteValid(byteValid), .byteReady(byteReady), .byteData(byteData), .busy(busy),
    .configured(configured), .failed(failed));
  ps_config_device #(.PorCycles(POR), .ConfigBytes(NB)) ps_config_device_i (
    .clk(clk), .reset(reset), .link(link.device), .autoRestart(autoRestart),
    .useUserClock(useUserClock), .dualPurposeDrive(dualPurposeDrive),
    .userStartupClock(userStartupClock), .userDataOut(userDataOut),
    .userMode(userMode), .configError(configError), .userDataIn(userDataIn));
  ps_link_props #(.PorCycles(POR)) ps_link_props_i (.clk(clk), .reset(reset),
    .configRequestN(link.configRequestN), .serialLoadClock(link.serialLoadClock),
    .statusLine(link.statusLine), .doneLine(link.doneLine),
    .chipSelectInN(link.chipSelectInN), .chainSelectOutN(link.chainSelectOutN),
    .devStatusOeN(link.devStatusOeN), .devDoneOeN(link.devDoneOeN),
    .devDataOeN(link.devDataOeN));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // user start-up clock of four bench clocks a period
  always @(posedge clk) begin
    ucDiv <= ~ucDiv;
    if (ucDiv) userStartupClock <= ~userStartupClock;
  end
  always @(posedge link.serialLoadClock) bitQ.push_back(link.serialLoadData);
  always @(negedge link.configRequestN) reqFalls = reqFalls + 1;
  // length of the latest status low pulse
  always @(posedge clk) begin
    if (link.statusLine === 1'b0) lowRun <= lowRun + 1;
    else if (lowRun != 0) begin
      lastLow <= lowRun;
      lowRun <= 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic pick(input int k);
    case (k)
      1: return link.doneLine;
      2: return userMode;
      3: return link.statusLine;
      4: return !link.doneLine;
      5: return !userMode;
      6: return bitQ.size() == 32;
      default: return failed;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim, output int n);
    n = 0;
    while (pick(k) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (pick(k) !== 1'b1) check(1'b0, 1'b1, "wait limit");
  endtask
  task automatic kick;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic push_word(input logic [31:0] w);
    for (int i = 0; i < NB; i++) begin
      byteValid <= 1'b1;
      byteData <= w[8*i +: 8];
      @(posedge clk);
      while (byteReady !== 1'b1) @(posedge clk);
    end
    byteValid <= 1'b0;
  endtask
  // full load; um is the count from done high to user mode
  task automatic load(input logic [31:0] w, output int um);
    int n;
    bitQ.delete();
    kick();
    wait_for(4, CF2ST0_MAX_CYC, n);
    push_word(w);
    wait_for(1, 4000, n);
    wait_for(2, 2000, um);
    check(configured, 1'b1, "configured flag");
  endtask
  task automatic t_first_load;
    int um;
    check(link.statusLine, 1'b0, "status at power-on");
    check(link.doneLine, 1'b0, "done before load");
    dualPurposeDrive <= 1'b1;
    dataRelease <= 1'b1;
    load(GOOD, um);
    check(um >= CD2UM_CYC && um <= CD2UM_MAX_NS / CLK_NS, 1'b1, "user mode delay");
    check(link.chainSelectOutN, 1'b0, "chain select");
    check(link.serialLoadClock, 1'b0, "clock parked");
    check(bitQ.size(), 32, "clock rises");
    for (int i = 0; i < 32; i++) check(bitQ[i], GOOD[i], "bit order");
    userDataOut <= 1'b1;
    tick(6);
    check(link.serialLoadData, 1'b1, "user pin high");
    check(userDataIn, 1'b1, "user pin read");
    userDataOut <= 1'b0;
    tick(6);
    check(link.serialLoadData, 1'b0, "user pin low");
    $display("test first_load finished");
  endtask
  task automatic t_bad_load;
    int n;
    kick();
    wait_for(4, CF2ST0_MAX_CYC, n);
    wait_for(5, CF2ST0_MAX_CYC, n);
    push_word(BAD);
    wait_for(7, 4000, n);
    check(configError, 1'b1, "error flag");
    check(link.statusLine, 1'b0, "status on error");
    wait_for(3, STATUS_MAX_CYC, n);
    tick(1);
    check(lastLow >= STATUS_MIN_CYC, 1'b1, "status pulse");
    check(link.doneLine, 1'b0, "done after error");
    load(GOOD, n);
    check(configError, 1'b0, "error cleared");
    $display("test bad_load finished");
  endtask
  task automatic t_unselected;
    int n;
    link.chipSelectInN <= 1'b1;
    bitQ.delete();
    kick();
    push_word(GOOD);
    wait_for(6, 3000, n);
    tick(20);
    check(link.doneLine, 1'b0, "done unselected");
    check(busy, 1'b1, "host still busy");
    link.chipSelectInN <= 1'b0;
    push_word(GOOD);
    wait_for(1, 4000, n);
    check(bitQ.size(), 64, "bits to done");
    wait_for(2, 2000, n);
    $display("test unselected finished");
  endtask
  task automatic t_user_clock;
    int um;
    useUserClock <= 1'b1;
    load(GOOD, um);
    check(um >= CD2CU_CYC + (USER_INIT_EDGES - 2) * UCP, 1'b1, "start early");
    check(um <= CD2CU_CYC + USER_INIT_EDGES * UCP + 20, 1'b1, "start late");
    useUserClock <= 1'b0;
    $display("test user_clock finished");
  endtask
  task automatic t_auto_restart;
    int n;
    autoRestart <= 1'b1;
    reqFalls = 0;
    kick();
    wait_for(4, CF2ST0_MAX_CYC, n);
    push_word(BAD);
    wait_for(7, 4000, n);
    wait_for(3, STATUS_MAX_CYC, n);
    push_word(GOOD);
    wait_for(1, 4000, n);
    check(reqFalls, 1, "request pulses");
    autoRestart <= 1'b0;
    $display("test auto_restart finished");
  endtask
  // hang guard
  initial begin
    #4000000;
    bad_count++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    start = 1'b0;
    autoRestart = 1'b0;
    dataRelease = 1'b0;
    byteValid = 1'b0;
    byteData = 8'h00;
    useUserClock = 1'b0;
    dualPurposeDrive = 1'b0;
    userDataOut = 1'b0;
    userStartupClock = 1'b0;
    ucDiv = 1'b0;
    link.chipSelectInN = 1'b0;
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_first_load();
    t_bad_load();
    t_unselected();
    t_user_clock();
    t_auto_restart();
    finish_test();
  end
endmodule
`default_nettype wire

/* src/byte_fifo.sv */
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int Width = 8,
  parameter int Depth = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int AW = $clog2(Depth);
  if (Depth < 2 || (1 << AW) != Depth) begin : badDepth
    $error("fifo depth must be a power of two");
  end
  logic [Width-1:0] mem [Depth];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic push, pop;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];
  always_comb begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      inReady <= 1'b0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      inReady <= (next_wrPtr - next_rdPtr) != (AW + 1)'(Depth);
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule
`default_nettype wire

/* src/config_link.sv */
// link between the configuration host and one configurable device
`timescale 1ns/1ps
`default_nettype none
interface config_link;
  logic configRequestN;
  logic serialLoadClock;
  logic hostDataOut;
  logic hostDataOeN;
  logic devDataOut;
  logic devDataOeN;
  logic devStatusOut;
  logic devStatusOeN;
  logic devDoneOut;
  logic devDoneOeN;
  logic chipSelectInN;
  logic chainSelectOutN;
  logic serialLoadData;
  logic statusLine;
  logic doneLine;
  // open-drain lines idle high through the pull-up
  assign statusLine = devStatusOeN ? 1'b1 : devStatusOut;
  assign doneLine = devDoneOeN ? 1'b1 : devDoneOut;
  assign serialLoadData = !devDataOeN ? devDataOut : (!hostDataOeN ? hostDataOut : 1'b1);
  modport device (
    input configRequestN, serialLoadClock, serialLoadData, statusLine, doneLine,
    input chipSelectInN,
    output devStatusOut, devStatusOeN, devDoneOut, devDoneOeN, devDataOut, devDataOeN,
    output chainSelectOutN
  );
  modport host (
    output configRequestN, serialLoadClock, hostDataOut, hostDataOeN,
    input statusLine, doneLine, serialLoadData
  );
endinterface
`default_nettype wire

/* src/ps_config_device.sv */
// configurable device end of the passive serial configuration link
// How it works
// RQ1 - own load finished drives chain select low
// RQ2 - newly selected device accepts next clock edge
// RQ3 - error pulls shared status low, chain restarts
// RQ4 - initialization waits for shared done high
// RQ5 - auto restart releases status within 100 us
// RQ6 - without auto restart host pulses request 2 us
// RQ7 - identical data: select held active, same timing
// RQ8 - request fall drives done, status low quickly
// RQ9 - power-up holds status low for reset delay
// RQ10 - status low pulses last 10 to 100 us
// RQ11 - status released within 100 us of request
// RQ12 - host waits 100 us before first clock
// RQ13 - host waits 2 us after status high
// RQ14 - link clock period at least 10 ns
// RQ15 - internal start-up enters user mode 20-40 us
// RQ16 - user clock: 4 link periods plus 299 edges
// RQ17 - host parks link clock at steady level
// RQ18 - data pin becomes user pin after loading
// RQ19 - user mode lines high; request fall reconfigures
// RQ20 - done held low until load complete
// RQ21 - host sends bytes least significant bit first
// RQ22 - data sampled on rising link clock
// RQ23 - unselected or finished device ignores link
`timescale 1ns/1ps
`default_nettype none
module ps_config_device #(
  parameter int PorCycles = ps_config_pkg::POR_CYC,
  parameter int ConfigBytes = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration link
  config_link.device link,
  // option settings
  input wire logic autoRestart,
  input wire logic useUserClock,
  input wire logic dualPurposeDrive,
  // user side
  input wire logic userStartupClock,
  input wire logic userDataOut,
  output logic userMode,
  output logic configError,
  output logic userDataIn
);
  import ps_config_pkg::*;
  if (PorCycles < 1 || PorCycles >= (1 << CNT_W)) begin : badPor
    $error("PorCycles out of range");
  end
  if (ConfigBytes < 2 || ConfigBytes > 65535) begin : badBytes
    $error("ConfigBytes out of range");
  end

  typedef enum logic [3:0] {
    sPor, sReset, sStart, sConfig, sError, sHalt, sWaitDone, sInit, sUser
  } devState_t;

  // two-stage synchronisers for every pin input
  logic [SY_N-1:0] syncA, syncB;
  logic prevClk, prevUsr;
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA <= '1;
      syncB <= '1;
      prevClk <= 1'b1;
      prevUsr <= 1'b1;
    end else begin
      syncA <= {userStartupClock, link.doneLine, link.statusLine, link.chipSelectInN,
                link.serialLoadData, link.serialLoadClock, link.configRequestN};
      syncB <= syncA;
      prevClk <= syncB[SY_CLK];
      prevUsr <= syncB[SY_USR];
    end
  end

  logic reqLow, statusHigh, doneHigh, selected, clkRise, usrRise;
  assign reqLow = !syncB[SY_REQ];
  assign statusHigh = syncB[SY_STA];
  assign doneHigh = syncB[SY_DONE];
  assign selected = !syncB[SY_SEL];
  assign clkRise = syncB[SY_CLK] && !prevClk;
  assign usrRise = syncB[SY_USR] && !prevUsr;

  devState_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [8:0] edges, next_edges;
  logic [2:0] bitCnt, next_bitCnt;
  logic [BYTE_BITS-1:0] shiftByte, next_shiftByte, check, next_check;
  logic [15:0] bytes, next_bytes;
  logic [BYTE_BITS-1:0] fullByte;
  logic statusOeN, doneOeN, chainOutN, dataOeN;
  logic next_statusOeN, next_doneOeN, next_chainOutN, next_dataOeN;
  logic next_configError, next_userMode, next_userDataIn;
  logic finished;

  // byte completed by the bit arriving now, least significant bit first
  assign fullByte = {syncB[SY_DAT], shiftByte[BYTE_BITS-1:1]};

  always_comb begin
    next_state = state;
    next_cnt = (cnt == '1) ? cnt : cnt + 1'b1;
    next_edges = edges;
    next_bitCnt = bitCnt;
    next_shiftByte = shiftByte;
    next_check = check;
    next_bytes = bytes;
    next_configError = configError;
    unique case (state)
      // RQ9 power-on delay
      sPor: begin
        if (cnt >= CNT_W'(PorCycles - 1)) begin
          next_state = sReset;
          next_cnt = '0;
        end
      end
      // RQ10 RQ11 status low at least the minimum, released after request rises
      sReset: begin
        if (!reqLow && cnt >= CNT_W'(STATUS_MIN_CYC - 1)) begin
          next_state = sStart;
        end
      end
      sStart: begin
        next_bitCnt = '0;
        next_bytes = '0;
        next_check = '0;
        if (statusHigh) begin
          next_state = sConfig;
        end
      end
      sConfig: begin
        // RQ3 another device pulled status low: restart with the chain
        if (!statusHigh) begin
          next_state = sStart;
        // RQ2 RQ22 RQ23 sample only while selected, on the rising edge
        end else if (selected && clkRise) begin
          next_shiftByte = fullByte;
          next_bitCnt = bitCnt + 1'b1;
          if (bitCnt == 3'(BYTE_BITS - 1)) begin
            next_check = check ^ fullByte;
            next_bytes = bytes + 1'b1;
            if (bytes == 16'(ConfigBytes - 1)) begin
              if ((check ^ fullByte) == '0) begin
                next_state = sWaitDone;
              end else begin
                // RQ3 checksum failure pulls the shared status low
                next_state = sError;
                next_cnt = '0;
                next_configError = 1'b1;
              end
            end
          end
        end
      end
      // RQ5 RQ10 error pulse held for the minimum width, then released
      sError: begin
        if (cnt >= CNT_W'(STATUS_MIN_CYC - 1)) begin
          next_state = autoRestart ? sStart : sHalt;
        end
      end
      // RQ6 waits for the host to pulse the request
      sHalt: begin
      end
      // RQ4 initialization starts only when the shared done line is high
      sWaitDone: begin
        if (!statusHigh) begin
          next_state = sStart;
        end else if (doneHigh) begin
          next_state = sInit;
          next_cnt = '0;
          next_edges = '0;
        end
      end
      sInit: begin
        if (!statusHigh) begin
          next_state = sStart;
        end else if (!useUserClock) begin
          // RQ15 internal start-up time
          if (cnt >= CNT_W'(CD2UM_CYC - 1)) begin
            next_state = sUser;
          end
        end else if (cnt >= CNT_W'(CD2CU_CYC) && usrRise) begin
          // RQ16 user clock counted once enabled
          next_edges = edges + 1'b1;
          if (edges == 9'(USER_INIT_EDGES - 1)) begin
            next_state = sUser;
          end
        end
      end
      sUser: begin
      end
    endcase
    // RQ8 RQ19 request fall restarts from any state other than power-on and reset
    if (reqLow && state != sPor && state != sReset) begin
      next_state = sReset;
      next_cnt = '0;
      next_configError = next_configError && !configError;
    end
    finished = next_state inside {sWaitDone, sInit, sUser};
    // RQ3 RQ9 status driven low in power-on, reset and error
    next_statusOeN = !(next_state inside {sPor, sReset, sError});
    // RQ20 done released only after the whole load
    next_doneOeN = finished;
    // RQ1 RQ7 pass the data destination down the chain
    next_chainOutN = !finished;
    // RQ18 data pin as a user pin under the dual-purpose setting
    next_dataOeN = !(next_state == sUser && dualPurposeDrive);
    next_userMode = next_state == sUser;
    next_userDataIn = (next_state == sUser) ? syncB[SY_DAT] : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= sPor;
      cnt <= '0;
      edges <= '0;
      bitCnt <= '0;
      shiftByte <= '0;
      check <= '0;
      bytes <= '0;
      statusOeN <= 1'b0;
      doneOeN <= 1'b0;
      chainOutN <= 1'b1;
      dataOeN <= 1'b1;
      configError <= 1'b0;
      userMode <= 1'b0;
      userDataIn <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      edges <= next_edges;
      bitCnt <= next_bitCnt;
      shiftByte <= next_shiftByte;
      check <= next_check;
      bytes <= next_bytes;
      statusOeN <= next_statusOeN;
      doneOeN <= next_doneOeN;
      chainOutN <= next_chainOutN;
      dataOeN <= next_dataOeN;
      configError <= next_configError;
      userMode <= next_userMode;
      userDataIn <= next_userDataIn;
    end
  end

  // open-drain lines only ever pull low
  assign link.devStatusOut = 1'b0;
  assign link.devDoneOut = 1'b0;
  assign link.devStatusOeN = statusOeN;
  assign link.devDoneOeN = doneOeN;
  assign link.chainSelectOutN = chainOutN;
  assign link.devDataOeN = dataOeN;
  assign link.devDataOut = userDataOut;
endmodule
`default_nettype wire

/* src/ps_config_host.sv */
// host end: buffers bytes and shifts them to the device chain
`timescale 1ns/1ps
`default_nettype none
module ps_config_host #(
  parameter int HalfCycles = ps_config_pkg::HALF_LINK_CYC,
  parameter int FifoDepth = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration link
  config_link.host link,
  // control
  input wire logic start,
  input wire logic autoRestart,
  input wire logic dataRelease,
  // byte stream in
  input wire logic byteValid,
  output logic byteReady,
  input wire logic [7:0] byteData,
  // status
  output logic busy,
  output logic configured,
  output logic failed
);
  import ps_config_pkg::*;
  if (HalfCycles < 1 || HalfCycles > 255) begin : badHalf
    $error("HalfCycles out of range");
  end

  typedef enum logic [2:0] {hIdle, hPulse, hWait, hShift, hDone, hFail} hostState_t;

  logic [1:0] staSync, doneSync;
  logic fifoValid, fifoPop;
  logic [BYTE_BITS-1:0] fifoData;

  byte_fifo #(.Width(BYTE_BITS), .Depth(FifoDepth)) buffer (
    .clk(clk),
    .reset(reset),
    .inValid(byteValid),
    .inReady(byteReady),
    .inData(byteData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  hostState_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, stCnt, next_stCnt;
  logic [7:0] half, next_half;
  logic [3:0] bitsLeft, next_bitsLeft;
  logic [BYTE_BITS-1:0] shreg, next_shreg;
  logic reqN, sclk, dat, oeN, next_reqN, next_sclk, next_dat, next_oeN;
  logic next_configured, next_failed, halfEnd;

  assign halfEnd = half >= 8'(HalfCycles - 1);

  always_comb begin
    next_state = state;
    next_cnt = (cnt == '1) ? cnt : cnt + 1'b1;
    next_stCnt = !staSync[1] ? '0 : ((stCnt == '1) ? stCnt : stCnt + 1'b1);
    next_half = halfEnd ? '0 : half + 1'b1;
    next_bitsLeft = bitsLeft;
    next_shreg = shreg;
    next_sclk = sclk;
    next_dat = dat;
    next_configured = configured;
    next_failed = failed;
    fifoPop = 1'b0;
    unique case (state)
      hIdle, hDone, hFail: begin
        if (start) begin
          next_state = hPulse;
          next_cnt = '0;
          next_configured = 1'b0;
          next_failed = 1'b0;
        end
      end
      // RQ6 request held low for the least pulse width
      hPulse: begin
        if (cnt >= CNT_W'(CFG_LOW_CYC - 1)) begin
          next_state = hWait;
          next_cnt = '0;
        end
      end
      // RQ12 RQ13 first rising edge only after both waits
      hWait: begin
        if (cnt >= CNT_W'(CF2CK_CYC) && stCnt >= CNT_W'(ST2CK_CYC)) begin
          next_state = hShift;
          next_half = '0;
          next_bitsLeft = '0;
        end
      end
      hShift: begin
        if (staSync[1] == 1'b0) begin
          // RQ5 with auto restart resend after status returns high
          next_failed = 1'b1;
          next_sclk = 1'b0;
          next_state = autoRestart ? hWait : hFail;
          next_cnt = CNT_W'(CF2CK_CYC);
        end else if (doneSync[1]) begin
          next_state = hDone;
          next_configured = 1'b1;
          next_sclk = 1'b0;
        // RQ14 half period of whole cycles keeps the clock slow
        end else if (halfEnd) begin
          if (sclk) begin
            next_sclk = 1'b0;
            next_dat = shreg[0];
            next_shreg = shreg >> 1;
          end else if (bitsLeft != '0) begin
            next_sclk = 1'b1;
            next_bitsLeft = bitsLeft - 1'b1;
          end else if (fifoValid) begin
            // RQ21 least significant bit goes out first
            fifoPop = 1'b1;
            next_dat = fifoData[0];
            next_shreg = fifoData >> 1;
            next_bitsLeft = 4'(BYTE_BITS);
          end
        end
      end
    endcase
    next_reqN = next_state != hPulse;
    // RQ17 clock parked low after loading; data driven low unless dataRelease releases it
    if (next_state == hDone) begin
      next_sclk = 1'b0;
      next_dat = 1'b0;
    end
    next_oeN = next_state == hDone && dataRelease;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      staSync <= '0;
      doneSync <= '0;
      state <= hIdle;
      cnt <= '0;
      stCnt <= '0;
      half <= '0;
      bitsLeft <= '0;
      shreg <= '0;
      reqN <= 1'b1;
      sclk <= 1'b0;
      dat <= 1'b0;
      oeN <= 1'b0;
      busy <= 1'b0;
      configured <= 1'b0;
      failed <= 1'b0;
    end else begin
      staSync <= {staSync[0], link.statusLine};
      doneSync <= {doneSync[0], link.doneLine};
      state <= next_state;
      cnt <= next_cnt;
      stCnt <= next_stCnt;
      half <= next_half;
      bitsLeft <= next_bitsLeft;
      shreg <= next_shreg;
      reqN <= next_reqN;
      sclk <= next_sclk;
      dat <= next_dat;
      oeN <= next_oeN;
      busy <= next_state inside {hPulse, hWait, hShift};
      configured <= next_configured;
      failed <= next_failed;
    end
  end

  assign link.configRequestN = reqN;
  assign link.serialLoadClock = sclk;
  assign link.hostDataOut = dat;
  assign link.hostDataOeN = oeN;
endmodule
`default_nettype wire

/* src/ps_config_pkg.sv */
// shared constants for the passive serial configuration link
package ps_config_pkg;
  localparam int CLK_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 17;
  localparam int POR_DELAY_MS = 12;
  localparam int CF2ST0_MAX_NS = 800;
  localparam int CFG_LOW_MIN_NS = 2000;
  localparam int STATUS_LOW_MIN_NS = 10000;
  localparam int STATUS_LOW_MAX_NS = 100000;
  localparam int CF2CK_MIN_NS = 100000;
  localparam int ST2CK_MIN_NS = 2000;
  localparam int CD2UM_MIN_NS = 20000;
  localparam int CD2UM_MAX_NS = 40000;
  localparam int CD2CU_PERIODS = 4;
  localparam int USER_INIT_EDGES = 299;
  // derived cycle counts: least times round up, longest round down
  localparam int POR_CYC = POR_DELAY_MS * 1000000 / CLK_NS;
  localparam int CF2ST0_MAX_CYC = CF2ST0_MAX_NS / CLK_NS;
  localparam int CFG_LOW_CYC = (CFG_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_MIN_CYC = (STATUS_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_MAX_CYC = STATUS_LOW_MAX_NS / CLK_NS;
  localparam int CF2CK_CYC = (CF2CK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int ST2CK_CYC = (ST2CK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CD2UM_CYC = (CD2UM_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CD2CU_CYC = (CD2CU_PERIODS * LINK_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_LINK_CYC = LINK_PERIOD_NS / 2 / CLK_NS;
  // positions of the synchronised device inputs
  localparam int SY_REQ = 0;
  localparam int SY_CLK = 1;
  localparam int SY_DAT = 2;
  localparam int SY_SEL = 3;
  localparam int SY_STA = 4;
  localparam int SY_DONE = 5;
  localparam int SY_USR = 6;
  localparam int SY_N = 7;
endpackage
